// ==== serial_eeprom_defines.svh ====
// Behaviour
// - 128-byte nonvolatile memory, serial access only
// - bit 2 drives clock, bit 1 data
// - data 1 releases, 0 pulls low; clock follows
// - power bit 1 powers memory, 0 tri-states
// - bits 7 to 3 read zero
// - power off: all bits read zero
// - reset sets clock, data, power to 1
// - data changes only while clock low
// - data falling, clock high means start
// - data rising, clock high means stop
// - one bit per clock, sampled high phase
// - write keeps only last sixteen bytes
// - memory acknowledges each received byte
// - acknowledge holds data low through high phase
// - no acknowledge while programming
// - master nacks last read byte; line released
// - control byte: code, three ignored, direction
// - direction 1 read, 0 write
// - ack control only on match and idle
// - byte write sequence; stop starts programming
`ifndef SERIAL_EEPROM_DEFINES_SVH
`define SERIAL_EEPROM_DEFINES_SVH
`define LC_OFFSET 8'h90
`define LC_SCL_BIT 2
`define LC_SDA_BIT 1
`define LC_PWR_BIT 0
`define LC_RESET 3'h7
// device-type code: value arbitrary
`define DEV_TYPE_CODE 4'h5
`define LAST_BIT 4'h7
`define ACK_SLOT 4'h8
// start parks the counter here so the clock fall right after it is not a bit
`define SKIP_FALL 4'hF
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define PROG_CYCLES_DEF 1000
`endif

// ==== serial_eeprom_pkg.sv ====
package serial_eeprom_pkg;
    typedef enum logic [2:0] {stIdle, stCtrl, stAddr, stData, stRead} state_t;
endpackage

// ==== reg_access_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
    logic wrEn;
    logic [7:0] wrData;
    logic [7:0] rdData;
    modport bus (output wrEn, output wrData, input rdData);
    modport regs (input wrEn, input wrData, output rdData);
endinterface
`default_nettype wire

// ==== axi_lite_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "serial_eeprom_defines.svh"
module axi_lite_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    reg_access_if.bus regs
);
    logic awHeld_q, wHeld_q, wLane_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic [7:0] wData_q;
    logic wHit, rHit;

    if (ADDR_W < 8) begin : g_chk
        $error("address too narrow for register offset");
    end

    assign wHit = awAddr_q == ADDR_W'(`LC_OFFSET);
    assign rHit = araddr == ADDR_W'(`LC_OFFSET);
    // only byte lane 0 carries the register
    assign regs.wrEn = awHeld_q && wHeld_q && !bvalid && wHit && wLane_q;
    assign regs.wrData = wData_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= 8'h00;
            wLane_q <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                awAddr_q <= awaddr;
                awHeld_q <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wData_q <= wdata[7:0];
                wLane_q <= wstrb[0];
                wHeld_q <= 1'b1;
                wready <= 1'b0;
            end
            if (awHeld_q && wHeld_q && !bvalid) begin
                bvalid <= 1'b1;
                bresp <= wHit ? `RESP_OKAY : `RESP_DECERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rHit ? {24'h00_0000, regs.rdData} : 32'h0000_0000;
            rresp <= rHit ? `RESP_OKAY : `RESP_DECERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== serial_eeprom_two_wire_port.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "serial_eeprom_defines.svh"
module serial_eeprom_two_wire_port #(
    parameter int MEM_DEPTH = 128,
    parameter int BUF_DEPTH = 16,
    parameter int PROG_CYCLES = `PROG_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sclOe,
    output logic sdaOut,
    output logic sdaOe
);
    localparam int AW = $clog2(MEM_DEPTH);
    localparam int BW = $clog2(BUF_DEPTH);
    localparam int TW = $clog2(PROG_CYCLES + 1);

    if (MEM_DEPTH != (1 << AW) || AW > 8 || BUF_DEPTH != (1 << BW) || BW < 1
        || BUF_DEPTH > MEM_DEPTH || PROG_CYCLES <= BUF_DEPTH) begin : g_chk
        $error("unsupported memory, buffer or programming size");
    end

    logic sclBit_q, sdaBit_q, pwrBit_q;
    logic [1:0] sync1_q, sync2_q, sync3_q, linePrev_q;
    logic [1:0] lineLvl;
    serial_eeprom_pkg::state_t state_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic memLow_q;
    logic [AW-1:0] ptr_q;
    logic [7:0] mem_q [MEM_DEPTH];
    logic [7:0] buf_q [BUF_DEPTH];
    logic [BW-1:0] bufWr_q, progRd_q;
    logic [BW:0] bufCnt_q, progLeft_q;
    logic [TW-1:0] progTimer_q;
    logic sclNow, sdaNow, start, stop, rise, fall;
    logic byteDone, ackEnd, readLoad, progBusy, progStart;

    reg_access_if regBus();

    axi_lite_regs #(.ADDR_W(8)) u_regs (
        .clock(clock),
        .srst(srst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .regs(regBus.bus)
    );

    // line-control register; edges come only from software writes
    always_ff @(posedge clock) begin
        if (srst) begin
            {sclBit_q, sdaBit_q, pwrBit_q} <= `LC_RESET;
        end else if (regBus.wrEn) begin
            sclBit_q <= regBus.wrData[`LC_SCL_BIT];
            sdaBit_q <= regBus.wrData[`LC_SDA_BIT];
            pwrBit_q <= regBus.wrData[`LC_PWR_BIT];
        end
    end

    assign regBus.rdData = pwrBit_q ? {5'h00, sclBit_q, sdaBit_q, pwrBit_q} : 8'h00;

    // pins; data is open drain, shared by software and the memory's ack and read data
    always_ff @(posedge clock) begin
        if (srst) begin
            sclOut <= 1'b1;
            sclOe <= 1'b1;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
        end else begin
            sclOut <= sclBit_q;
            sclOe <= pwrBit_q;
            sdaOut <= 1'b0;
            sdaOe <= pwrBit_q && (!sdaBit_q || memLow_q);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sync1_q <= 2'h3;
            sync2_q <= 2'h3;
            sync3_q <= 2'h3;
            linePrev_q <= 2'h3;
        end else begin
            sync1_q <= {sclIn, sdaIn};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            linePrev_q <= lineLvl;
        end
    end

    // a level counts once two later stages agree; rejects one-cycle glitches
    for (genvar g = 0; g < 2; g++) begin : g_filt
        logic lvl_q;
        always_ff @(posedge clock) begin
            if (srst) begin
                lvl_q <= 1'b1;
            end else if (sync2_q[g] == sync3_q[g]) begin
                lvl_q <= sync3_q[g];
            end
        end
        assign lineLvl[g] = lvl_q;
    end

    assign sclNow = lineLvl[1];
    assign sdaNow = lineLvl[0];
    assign start = pwrBit_q && sclNow && linePrev_q[1] && linePrev_q[0] && !sdaNow;
    assign stop = pwrBit_q && sclNow && linePrev_q[1] && !linePrev_q[0] && sdaNow;
    assign rise = pwrBit_q && sclNow && !linePrev_q[1];
    assign fall = pwrBit_q && !sclNow && linePrev_q[1];
    assign byteDone = fall && bitCnt_q == `LAST_BIT && state_q != serial_eeprom_pkg::stIdle;
    assign ackEnd = fall && bitCnt_q == `ACK_SLOT;
    assign readLoad = ackEnd && ((state_q == serial_eeprom_pkg::stCtrl && shift_q[0])
        || state_q == serial_eeprom_pkg::stRead);
    assign progBusy = progTimer_q != '0;
    assign progStart = stop && state_q == serial_eeprom_pkg::stData
        && bufCnt_q != '0 && !progBusy;

    // bus engine; watches the lines whenever powered
    always_ff @(posedge clock) begin
        if (srst || !pwrBit_q) begin
            state_q <= serial_eeprom_pkg::stIdle;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            memLow_q <= 1'b0;
        end else if (start) begin
            state_q <= serial_eeprom_pkg::stCtrl;
            bitCnt_q <= `SKIP_FALL;
            memLow_q <= 1'b0;
        end else if (stop) begin
            state_q <= serial_eeprom_pkg::stIdle;
            memLow_q <= 1'b0;
        end else if (rise && state_q == serial_eeprom_pkg::stRead) begin
            if (bitCnt_q == `ACK_SLOT && sdaNow) begin
                state_q <= serial_eeprom_pkg::stIdle;
            end
        end else if (rise && state_q != serial_eeprom_pkg::stIdle
                     && bitCnt_q != `ACK_SLOT) begin
            shift_q <= {shift_q[6:0], sdaNow};
        end else if (fall && state_q != serial_eeprom_pkg::stIdle) begin
            if (bitCnt_q < `LAST_BIT) begin
                bitCnt_q <= bitCnt_q + 4'h1;
                if (state_q == serial_eeprom_pkg::stRead) begin
                    shift_q <= {shift_q[6:0], 1'b0};
                    memLow_q <= !shift_q[6];
                end
            end else if (bitCnt_q == `LAST_BIT) begin
                bitCnt_q <= `ACK_SLOT;
                unique case (state_q)
                    serial_eeprom_pkg::stCtrl: begin
                        if (shift_q[7:4] == `DEV_TYPE_CODE && !progBusy) begin
                            memLow_q <= 1'b1;
                        end else begin
                            state_q <= serial_eeprom_pkg::stIdle;
                        end
                    end
                    serial_eeprom_pkg::stAddr,
                    serial_eeprom_pkg::stData: memLow_q <= 1'b1;
                    serial_eeprom_pkg::stRead: memLow_q <= 1'b0;
                    serial_eeprom_pkg::stIdle: memLow_q <= 1'b0;
                endcase
            end else if (bitCnt_q == `ACK_SLOT) begin
                bitCnt_q <= 4'h0;
                memLow_q <= 1'b0;
                if (readLoad) begin
                    state_q <= serial_eeprom_pkg::stRead;
                    shift_q <= mem_q[ptr_q];
                    memLow_q <= !mem_q[ptr_q][7];
                end else if (state_q == serial_eeprom_pkg::stCtrl) begin
                    state_q <= serial_eeprom_pkg::stAddr;
                end else if (state_q == serial_eeprom_pkg::stAddr) begin
                    state_q <= serial_eeprom_pkg::stData;
                end
            end else begin
                bitCnt_q <= 4'h0;
            end
        end
    end

    // one shared pointer; writes never meet reads, since busy blocks the ack
    always_ff @(posedge clock) begin
        if (srst) begin
            ptr_q <= '0;
        end else if (progLeft_q != '0) begin
            ptr_q <= ptr_q + AW'(1);
        end else if (byteDone && state_q == serial_eeprom_pkg::stAddr) begin
            ptr_q <= shift_q[AW-1:0];
        end else if (readLoad) begin
            ptr_q <= ptr_q + AW'(1);
        end
    end

    // write buffer: a ring, so excess bytes displace the oldest
    always_ff @(posedge clock) begin
        if (srst || start) begin
            bufWr_q <= '0;
            bufCnt_q <= '0;
        end else if (byteDone && state_q == serial_eeprom_pkg::stData) begin
            buf_q[bufWr_q] <= shift_q;
            bufWr_q <= bufWr_q + BW'(1);
            if (bufCnt_q != (BW+1)'(BUF_DEPTH)) begin
                bufCnt_q <= bufCnt_q + (BW+1)'(1);
            end
        end
    end

    // programming: copy buffer oldest first while busy holds for the cycle time
    always_ff @(posedge clock) begin
        if (srst) begin
            progTimer_q <= '0;
            progLeft_q <= '0;
            progRd_q <= '0;
        end else if (progStart) begin
            progTimer_q <= TW'(PROG_CYCLES);
            progLeft_q <= bufCnt_q;
            progRd_q <= bufCnt_q == (BW+1)'(BUF_DEPTH) ? bufWr_q : '0;
        end else begin
            if (progBusy) begin
                progTimer_q <= progTimer_q - TW'(1);
            end
            if (progLeft_q != '0) begin
                progLeft_q <= progLeft_q - (BW+1)'(1);
                progRd_q <= progRd_q + BW'(1);
            end
        end
    end

    // no reset: contents survive reset and power-down
    always_ff @(posedge clock) begin
        if (progLeft_q != '0) begin
            mem_q[ptr_q] <= buf_q[progRd_q];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_regReset;
        $past(srst) |-> regBus.rdData == {5'h00, `LC_RESET};
    endproperty
    a_regReset: assert property (p_regReset) else $error("reset value wrong");

    property p_readZero;
        !pwrBit_q |-> regBus.rdData == 8'h00;
    endproperty
    a_readZero: assert property (p_readZero) else $error("read not zero");

    property p_upperZero;
        regBus.rdData[7:3] == 5'h00;
    endproperty
    a_upperZero: assert property (p_upperZero) else $error("upper bits set");

    property p_sclPin;
        regBus.wrEn && regBus.wrData[`LC_PWR_BIT] |=> ##1 sclOe
            && sclOut == $past(regBus.wrData[`LC_SCL_BIT], 2);
    endproperty
    a_sclPin: assert property (p_sclPin) else $error("clock pin lag");

    property p_powerOff;
        !pwrBit_q |=> !sclOe && !sdaOe;
    endproperty
    a_powerOff: assert property (p_powerOff) else $error("lines driven off");

    property p_sdaRelease;
        pwrBit_q && sdaBit_q && !memLow_q |=> !sdaOe;
    endproperty
    a_sdaRelease: assert property (p_sdaRelease) else $error("data not released");

    property p_noAckBusy;
        byteDone && state_q == serial_eeprom_pkg::stCtrl && progBusy |=> !memLow_q;
    endproperty
    a_noAckBusy: assert property (p_noAckBusy) else $error("ack while busy");

    property p_ackHold;
        memLow_q && bitCnt_q == `ACK_SLOT && !fall && !start && !stop && pwrBit_q
            |=> memLow_q ##1 sdaOe;
    endproperty
    a_ackHold: assert property (p_ackHold) else $error("ack dropped");

    property p_addrLoad;
        byteDone && state_q == serial_eeprom_pkg::stAddr && progLeft_q == '0
            |=> ptr_q == $past(shift_q[AW-1:0]);
    endproperty
    a_addrLoad: assert property (p_addrLoad) else $error("pointer not loaded");

    property p_progStart;
        progStart |=> progBusy [*8];
    endproperty
    a_progStart: assert property (p_progStart) else $error("programming short");

    property p_startCtrl;
        start |=> state_q == serial_eeprom_pkg::stCtrl && bitCnt_q == `SKIP_FALL;
    endproperty
    a_startCtrl: assert property (p_startCtrl) else $error("start not taken");

    property p_stopIdle;
        stop |=> state_q == serial_eeprom_pkg::stIdle && !memLow_q;
    endproperty
    a_stopIdle: assert property (p_stopIdle) else $error("stop not taken");

    property p_ctrlNack;
        byteDone && state_q == serial_eeprom_pkg::stCtrl && shift_q[7:4] != `DEV_TYPE_CODE
            |=> state_q == serial_eeprom_pkg::stIdle && !memLow_q;
    endproperty
    a_ctrlNack: assert property (p_ctrlNack) else $error("foreign code acked");

    c_start: cover property (start);
    c_prog: cover property (progStart);
    c_read: cover property (readLoad);
    c_wrap: cover property (byteDone && state_q == serial_eeprom_pkg::stData
        && bufCnt_q == (BW+1)'(BUF_DEPTH));
endmodule
`default_nettype wire

// ==== line_master_model.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "serial_eeprom_defines.svh"
module line_master_model (
    input wire logic clock,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    input wire logic sdaWire
);
    initial begin
        awaddr <= 8'h00;
        awvalid <= 1'b0;
        wdata <= 32'h00000000;
        wstrb <= 4'h0;
        wvalid <= 1'b0;
        bready <= 1'b0;
        araddr <= 8'h00;
        arvalid <= 1'b0;
        rready <= 1'b0;
    end

    // address and data offered together, each dropped once taken
    task automatic axiWrite(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
            output logic [1:0] r);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clock);
            if (!awDone && awready) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clock); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clock); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // one level per write; held long enough for the synchroniser
    task automatic setLines(input logic c, input logic d);
        logic [1:0] r;
        axiWrite(`LC_OFFSET, {5'h00, c, d, 1'b1}, 4'h1, r);
        repeat (8) @(posedge clock);
    endtask

    task automatic bitXfer(input logic b, output logic s);
        setLines(1'b0, b);
        setLines(1'b1, b);
        s = sdaWire;
    endtask

    task automatic startCond();
        setLines(1'b0, 1'b1);
        setLines(1'b1, 1'b1);
        setLines(1'b1, 1'b0);
    endtask

    task automatic stopCond();
        setLines(1'b0, 1'b0);
        setLines(1'b1, 1'b0);
        setLines(1'b1, 1'b1);
    endtask

    task automatic sendByte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitXfer(v[i], s);
        end
        bitXfer(1'b1, s);
        ack = !s;
    endtask

    task automatic recvByte(input logic last, output logic [7:0] v, output logic s);
        for (int i = 7; i >= 0; i--) begin
            bitXfer(1'b1, s);
            v[i] = s;
        end
        bitXfer(last, s);
    endtask
endmodule
`default_nettype wire

// ==== serial_eeprom_two_wire_port_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "serial_eeprom_defines.svh"
`define CHECK(got, exp) \
    begin \
        nCompared++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("FAIL t=%0t got %0h exp %0h", $time, (got), (exp)); \
        end \
    end
module serial_eeprom_two_wire_port_test;
    // programming shortened; still far above the buffer depth
    localparam int PROG = 400;
    logic clock, srst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sclOut, sclOe, sdaOut, sdaOe, sclWire, sdaWire;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int errors = 0;
    int nCompared = 0;
    int cycles = 0;

    // pull-ups on both wires
    assign sclWire = sclOe ? sclOut : 1'b1;
    assign sdaWire = sdaOe ? sdaOut : 1'b1;

    serial_eeprom_two_wire_port #(.PROG_CYCLES(PROG)) dut_u (
        .clock, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .sclIn(sclWire), .sdaIn(sdaWire), .sclOut, .sclOe, .sdaOut, .sdaOe
    );

    line_master_model softMaster (
        .clock, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .sdaWire
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic summarize();
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // whole run is near 11k cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            summarize();
        end
    end

    task automatic regTest();
        logic [31:0] d;
        logic [1:0] r;
        `CHECK({sclWire, sdaWire}, 2'h3)
        softMaster.axiRead(`LC_OFFSET, d, r);
        `CHECK(d, 32'h00000007)
        softMaster.axiRead(8'h94, d, r);
        `CHECK({r, d}, {`RESP_DECERR, 32'h00000000})
        softMaster.axiWrite(`LC_OFFSET, 8'h03, 4'h1, r);
        repeat (2) @(posedge clock);
        `CHECK({sclWire, sdaWire}, 2'h1)
        softMaster.axiWrite(`LC_OFFSET, 8'hF9, 4'h1, r);
        softMaster.axiWrite(`LC_OFFSET, 8'h07, 4'h0, r);
        `CHECK(r, `RESP_OKAY)
        softMaster.axiRead(`LC_OFFSET, d, r);
        `CHECK(d, 32'h00000001)
        `CHECK({sclWire, sdaWire}, 2'h0)
        softMaster.axiWrite(`LC_OFFSET, 8'h0E, 4'h1, r);
        repeat (2) @(posedge clock);
        `CHECK({sclOe, sdaOe}, 2'h0)
        softMaster.axiRead(`LC_OFFSET, d, r);
        `CHECK(d, 32'h00000000)
        softMaster.axiWrite(`LC_OFFSET, 8'h07, 4'h1, r);
        softMaster.axiRead(`LC_OFFSET, d, r);
        `CHECK(d, 32'h00000007)
        $display("regTest done");
    endtask

    // poll right after stop must go unanswered
    task automatic writeTest();
        logic a;
        softMaster.startCond();
        softMaster.sendByte(8'h5E, a);
        `CHECK(a, 1'b1)
        softMaster.sendByte(8'h85, a);
        `CHECK(a, 1'b1)
        softMaster.sendByte(8'hA5, a);
        `CHECK(a, 1'b1)
        softMaster.stopCond();
        softMaster.startCond();
        softMaster.sendByte(8'h5E, a);
        `CHECK(a, 1'b0)
        softMaster.stopCond();
        repeat (PROG) @(posedge clock);
        $display("writeTest done");
    endtask

    task automatic readTest();
        logic a;
        logic s;
        logic [7:0] v;
        softMaster.startCond();
        softMaster.sendByte(8'h3E, a);
        `CHECK(a, 1'b0)
        softMaster.startCond();
        softMaster.sendByte(8'h5E, a);
        softMaster.sendByte(8'h05, a);
        softMaster.startCond();
        softMaster.sendByte(8'h5F, a);
        `CHECK(a, 1'b1)
        softMaster.recvByte(1'b1, v, s);
        `CHECK(v, 8'hA5)
        `CHECK(s, 1'b1)
        softMaster.stopCond();
        $display("readTest done");
    endtask

    // eighteen bytes sent; the first two are lost
    task automatic overflowTest();
        logic a;
        logic s;
        logic [7:0] v;
        softMaster.startCond();
        softMaster.sendByte(8'h5E, a);
        softMaster.sendByte(8'h10, a);
        for (int i = 0; i < 18; i++) begin
            softMaster.sendByte(8'hC0 + 8'(i), a);
            `CHECK(a, 1'b1)
        end
        softMaster.stopCond();
        repeat (PROG) @(posedge clock);
        softMaster.startCond();
        softMaster.sendByte(8'h5E, a);
        softMaster.sendByte(8'h10, a);
        softMaster.startCond();
        softMaster.sendByte(8'h5F, a);
        for (int i = 0; i < 16; i++) begin
            softMaster.recvByte(i == 15, v, s);
            `CHECK(v, 8'hC2 + 8'(i))
        end
        softMaster.stopCond();
        $display("overflowTest done");
    endtask

    initial begin
        srst <= 1'b1;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        regTest();
        writeTest();
        readTest();
        overflowTest();
        summarize();
    end
endmodule
`undef CHECK
`default_nettype wire
